/* File: common/touch_sense_regs.vh */
// Summary of operation
// - Read-only sensor state register, bit n is channel n state, resets to zero.
// - Clock setting bit 7 drives clock output; off at 0 unless primary-chip mode.
// - Clock setting bit 6 selects external clock, stops oscillator; secondary mode forces it.
// - Clock setting bit 5 unused; controller writes zero, reads may return either.
// - Bits 4:3 divide oscillator by 64, 16, 4 or 1; reset code 01.
// - Bits 2:0 tune oscillator 0.5 to 1.75 times nominal; reset code 100.
// - Channels sampled in turn, one per internal clock, each at clock over 8.
// - Secondary-chip mode stops internal clock generator, sampling runs from clock input.
// - Channel enable register, 1 enables channel, resets to all ones.
// - Mask mode 0: disabled channels sampled, events do not update state or interrupt.
// - Mask mode 1: only enabled channels are sampled, disabled ones skipped.
// - Channel newly enabled runs the fast start-up sequence.
// - Registers and bus stay accessible and keep values with core supply off.
// - Power-on resets supply-domain registers including regulator-off, so regulator starts on.
// - After core reset each channel fast-charges, then fine steps, then enables counters.
// - Start-up sequencing runs independently per channel.
// - Clock and enable registers reached only by their own write and read commands.
// - A read with no command returns the sensor state register one cycle after the request.
// - Reading the sensor state register clears a pending interrupt indication.
`ifndef TOUCH_SENSE_REGS_VH
`define TOUCH_SENSE_REGS_VH
`define CMD_NONE 3'h0
`define CMD_READ_SENSOR 3'h1
`define CMD_WRITE_CLOCK 3'h2
`define CMD_READ_CLOCK 3'h3
`define CMD_WRITE_MASK 3'h4
`define CMD_READ_MASK 3'h5
`define SENSOR_STATE_RESET 8'h00
`define CLOCK_SETTING_RESET 8'h0C
`define CHANNEL_ENABLE_RESET 8'hFF
`define CLK_OUT_BIT 7
`define CLK_IN_BIT 6
`define UNUSED_BIT 5
`define COARSE_HI 4
`define COARSE_LO 3
`define TUNE_HI 2
`define TUNE_LO 0
`define NUM_CHANNELS 8
`define COARSE_DIV64 2'h0
`define COARSE_DIV16 2'h1
`define COARSE_DIV4 2'h2
`define COARSE_DIV1 2'h3
`define FAST_THRESHOLD 6'h30
`define FINAL_TARGET 6'h3F
`define FINE_STEP 6'h01
`define FAST_STEP 6'h08
`define DIV_LIMIT_64 6'h3F
`define DIV_LIMIT_16 6'h0F
`define DIV_LIMIT_4 6'h03
`define DIV_LIMIT_1 6'h00
`define REGULATOR_OFF_RESET 1'b0
`endif

/* File: rtl/channel_startup.v */
`timescale 1ns/10ps
`include "touch_sense_regs.vh"
// Per-channel start-up: fast charge, fine charge, then counters live
module channel_startup #(
  parameter [5:0] FAST_THRESHOLD = `FAST_THRESHOLD,
  parameter [5:0] FINAL_TARGET = `FINAL_TARGET
) (
  input wire clk,
  input wire rst_n,
  input wire core_rst_n,
  input wire restart,
  input wire sample_en,
  output reg ready
);
  localparam ST_FAST = 3'b001;
  localparam ST_FINE = 3'b010;
  localparam ST_RUN = 3'b100;
  reg [2:0] state_reg;
  reg [5:0] charge_reg;

  // Charge level progresses only on this channel's own sample slot
  always @(posedge clk) begin
    if (!rst_n || !core_rst_n || restart) begin
      state_reg <= ST_FAST;
      charge_reg <= 6'h00;
      ready <= 1'b0;
    end else if (sample_en) begin
      case (state_reg)
        ST_FAST: begin
          if (charge_reg >= FAST_THRESHOLD) begin
            state_reg <= ST_FINE;
          end else begin
            charge_reg <= charge_reg + `FAST_STEP;
          end
        end
        ST_FINE: begin
          if (charge_reg >= FINAL_TARGET) begin
            state_reg <= ST_RUN;
            ready <= 1'b1; // counters enabled
          end else begin
            charge_reg <= charge_reg + `FINE_STEP;
          end
        end
        ST_RUN: begin
          ready <= 1'b1;
        end
        default: begin
          state_reg <= ST_FAST;
        end
      endcase
    end
  end
endmodule // channel_startup

/* File: rtl/touch_sense_clock_mask_regs.v */
`timescale 1ns/10ps
`include "touch_sense_regs.vh"
// Register bank, clock divider, channel scan and start-up control
module touch_sense_clock_mask_regs #(
  parameter [5:0] FAST_THRESHOLD = `FAST_THRESHOLD
) (
  input wire CORE_CLK,
  input wire RST_N,
  input wire CORE_RST_N,
  input wire [2:0] CMD,
  input wire CMD_VALID,
  input wire [7:0] WR_DATA,
  output reg [7:0] RD_DATA,
  output reg RD_VALID,
  input wire PRIMARY_MODE,
  input wire SECONDARY_MODE,
  input wire MASK_POWER_MODE,
  input wire REGULATOR_OFF_WR,
  input wire REGULATOR_OFF_WE,
  output wire REGULATOR_OFF,
  input wire CLK_IN,
  output reg CLK_OUT,
  input wire [7:0] SENSE_IN,
  output wire [7:0] SAMPLE_SEL,
  output wire OSC_ENABLE,
  output wire [2:0] OSC_TUNING,
  output wire [7:0] CHANNEL_READY,
  output reg INT_PENDING
);
  reg [7:0] sensor_state_reg;
  reg [7:0] clock_setting_reg;
  reg [7:0] channel_enable_reg;
  reg regulator_off_reg;
  reg [7:0] enable_prev_reg;
  reg [5:0] div_cnt_reg;
  reg [5:0] div_limit;
  reg [2:0] chan_idx_reg;
  reg clk_in_s1_reg;
  reg clk_in_s2_reg;
  reg clk_in_s3_reg;
  reg [7:0] sense_s1_reg;
  reg [7:0] sense_s2_reg;
  reg [7:0] sensor_state_next;
  reg [2:0] idx_next;
  reg found;
  integer i;
  integer j;
  wire clk_in_sel;
  wire osc_tick;
  wire ext_tick;
  wire tick;
  wire [7:0] restart;
  wire [7:0] slot;
  wire scan_idle;
  wire chan_live;

  // Synchronisers for clock input and channel comparator outputs
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      clk_in_s1_reg <= 1'b0;
      clk_in_s2_reg <= 1'b0;
      clk_in_s3_reg <= 1'b0;
      sense_s1_reg <= 8'h00;
      sense_s2_reg <= 8'h00;
    end else begin
      clk_in_s1_reg <= CLK_IN;
      clk_in_s2_reg <= clk_in_s1_reg;
      clk_in_s3_reg <= clk_in_s2_reg;
      sense_s1_reg <= SENSE_IN;
      sense_s2_reg <= sense_s1_reg;
    end
  end

  // Clock source choice
  assign clk_in_sel = clock_setting_reg[`CLK_IN_BIT] | SECONDARY_MODE;
  assign OSC_ENABLE = ~clk_in_sel;
  assign OSC_TUNING = clock_setting_reg[`TUNE_HI:`TUNE_LO];
  // Falling edge of input clock samples, opposite phase to primary
  assign ext_tick = clk_in_s3_reg & ~clk_in_s2_reg;

  // Coarse divider limit
  always @* begin
    case (clock_setting_reg[`COARSE_HI:`COARSE_LO])
      `COARSE_DIV64: div_limit = `DIV_LIMIT_64;
      `COARSE_DIV16: div_limit = `DIV_LIMIT_16;
      `COARSE_DIV4: div_limit = `DIV_LIMIT_4;
      `COARSE_DIV1: div_limit = `DIV_LIMIT_1;
      default: div_limit = `DIV_LIMIT_16;
    endcase
  end

  // Divider from core clock, stopped when external clock is used
  always @(posedge CORE_CLK) begin
    if (!RST_N || clk_in_sel) begin
      div_cnt_reg <= 6'h00;
    end else if (div_cnt_reg >= div_limit) begin
      div_cnt_reg <= 6'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end
  assign osc_tick = ~clk_in_sel & (div_cnt_reg >= div_limit);
  assign tick = clk_in_sel ? ext_tick : osc_tick;

  // Clock output toggles each oscillator tick when enabled
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      CLK_OUT <= 1'b0;
    end else if (!(clock_setting_reg[`CLK_OUT_BIT] | PRIMARY_MODE)) begin
      CLK_OUT <= 1'b0;
    end else if (osc_tick) begin
      CLK_OUT <= ~CLK_OUT;
    end
  end

  // Next channel to sample; skip disabled ones in low-power mode
  assign scan_idle = MASK_POWER_MODE && (channel_enable_reg == 8'h00);
  always @* begin
    idx_next = chan_idx_reg + 3'h1;
    found = 1'b0;
    for (i = 1; i <= `NUM_CHANNELS; i = i + 1) begin
      if (!found && (!MASK_POWER_MODE || channel_enable_reg[(chan_idx_reg + i) % `NUM_CHANNELS])) begin
        idx_next = chan_idx_reg + i[2:0];
        found = 1'b1;
      end
    end
  end

  // Sequential scan, one channel per internal clock
  always @(posedge CORE_CLK) begin
    if (!RST_N || !CORE_RST_N) begin
      chan_idx_reg <= 3'h0;
    end else if (tick && !scan_idle) begin
      chan_idx_reg <= idx_next;
    end
  end
  // Low-power mode drops a slot landing on a channel that was just disabled
  assign chan_live = !MASK_POWER_MODE || channel_enable_reg[chan_idx_reg];
  assign slot = (tick && !scan_idle && chan_live) ? (8'h01 << chan_idx_reg) : 8'h00;
  assign SAMPLE_SEL = slot;

  // Newly enabled channels restart their start-up
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      enable_prev_reg <= `CHANNEL_ENABLE_RESET;
    end else begin
      enable_prev_reg <= channel_enable_reg;
    end
  end
  assign restart = channel_enable_reg & ~enable_prev_reg;

  // One start-up sequencer per channel
  genvar g;
  generate
    for (g = 0; g < `NUM_CHANNELS; g = g + 1) begin : gen_start
      channel_startup #(
        .FAST_THRESHOLD(FAST_THRESHOLD),
        .FINAL_TARGET(`FINAL_TARGET)
      ) u_start (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .core_rst_n(CORE_RST_N),
        .restart(restart[g]),
        .sample_en(slot[g]),
        .ready(CHANNEL_READY[g])
      );
    end
  endgenerate

  // Sensor state: sampled channel updates only if enabled and operational
  always @* begin
    sensor_state_next = sensor_state_reg;
    for (j = 0; j < `NUM_CHANNELS; j = j + 1) begin
      if (slot[j] && channel_enable_reg[j] && CHANNEL_READY[j]) begin
        sensor_state_next[j] = sense_s2_reg[j];
      end
    end
  end

  // Register bank in the always-on supply domain, only system reset clears it
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sensor_state_reg <= `SENSOR_STATE_RESET;
      clock_setting_reg <= `CLOCK_SETTING_RESET;
      channel_enable_reg <= `CHANNEL_ENABLE_RESET;
      regulator_off_reg <= `REGULATOR_OFF_RESET;
    end else begin
      sensor_state_reg <= sensor_state_next;
      if (CMD_VALID && CMD == `CMD_WRITE_CLOCK) begin
        clock_setting_reg <= {WR_DATA[7:6], 1'b0, WR_DATA[4:0]};
      end
      if (CMD_VALID && CMD == `CMD_WRITE_MASK) begin
        channel_enable_reg <= WR_DATA;
      end
      if (REGULATOR_OFF_WE) begin
        regulator_off_reg <= REGULATOR_OFF_WR;
      end
    end
  end
  assign REGULATOR_OFF = regulator_off_reg;

  // Read path, one cycle after the command
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RD_DATA <= 8'h00;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= 1'b0;
      if (CMD_VALID) begin
        case (CMD)
          `CMD_NONE, `CMD_READ_SENSOR: begin
            RD_DATA <= sensor_state_reg;
            RD_VALID <= 1'b1;
          end
          `CMD_READ_CLOCK: begin
            RD_DATA <= clock_setting_reg;
            RD_VALID <= 1'b1;
          end
          `CMD_READ_MASK: begin
            RD_DATA <= channel_enable_reg;
            RD_VALID <= 1'b1;
          end
          default: begin
            RD_DATA <= RD_DATA;
          end
        endcase
      end
    end
  end

  // Pending indication: set on a state change, cleared by a state read; set wins
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      INT_PENDING <= 1'b0;
    end else if (sensor_state_next != sensor_state_reg) begin
      INT_PENDING <= 1'b1;
    end else if (CMD_VALID && (CMD == `CMD_NONE || CMD == `CMD_READ_SENSOR)) begin
      INT_PENDING <= 1'b0;
    end
  end
endmodule // touch_sense_clock_mask_regs

/* File: verif/touch_sense_clock_mask_regs_checker.sv */
`timescale 1ns/10ps
// Port relations of the register and scan block
module touch_sense_clock_mask_regs_checker (
  input wire CORE_CLK,
  input wire RST_N,
  input wire CORE_RST_N,
  input wire [2:0] CMD,
  input wire CMD_VALID,
  input wire [7:0] WR_DATA,
  input wire [7:0] RD_DATA,
  input wire RD_VALID,
  input wire SECONDARY_MODE,
  input wire REGULATOR_OFF_WR,
  input wire REGULATOR_OFF_WE,
  input wire REGULATOR_OFF,
  input wire [7:0] SAMPLE_SEL,
  input wire OSC_ENABLE,
  input wire [2:0] OSC_TUNING,
  input wire [7:0] CHANNEL_READY
);
  // Read request decode and tuning field of write data
  wire is_rd = CMD_VALID && (CMD == 3'h0 || CMD == 3'h1 || CMD == 3'h3 || CMD == 3'h5);
  wire [2:0] wr_tune = WR_DATA[2:0];
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rd;
    is_rd;
  endsequence
  sequence s_clk_wr;
    CMD_VALID && CMD == 3'h2;
  endsequence
  a_read_answer: assert property (s_rd |=> RD_VALID)
    else $error("read not answered");
  a_no_stray: assert property (!is_rd |=> !RD_VALID)
    else $error("stray read answer");
  a_tune_write: assert property (s_clk_wr |=> OSC_TUNING == $past(wr_tune))
    else $error("tuning not taken");
  a_tune_echo: assert property (CMD_VALID && CMD == 3'h3 |=> RD_DATA[2:0] == $past(OSC_TUNING))
    else $error("bad tuning read");
  a_osc_off: assert property (SECONDARY_MODE |-> !OSC_ENABLE)
    else $error("oscillator left on");
  a_one_slot: assert property (SAMPLE_SEL != 8'h00 |-> $onehot(SAMPLE_SEL))
    else $error("two slots at once");
  a_reg_off: assert property (REGULATOR_OFF_WE |=> REGULATOR_OFF == $past(REGULATOR_OFF_WR))
    else $error("regulator bit not taken");
  a_reg_keep: assert property (!REGULATOR_OFF_WE |=> $stable(REGULATOR_OFF))
    else $error("regulator bit moved");
  a_core_clear: assert property (!CORE_RST_N |=> CHANNEL_READY == 8'h00)
    else $error("ready kept in core reset");
  a_slow_start: assert property ($rose(CORE_RST_N) |-> (CHANNEL_READY == 8'h00) [*4])
    else $error("ready too soon");
endmodule // touch_sense_clock_mask_regs_checker

/* File: verif/sys_ctrl_model.sv */
`timescale 1ns/10ps
// Controller side: one command per call, held valid for one cycle
module sys_ctrl_model (
  input wire clk,
  input wire [7:0] rd_data,
  input wire rd_valid,
  output reg [2:0] cmd,
  output reg cmd_valid,
  output reg [7:0] wr_data
);
  initial begin
    cmd = 3'h0;
    cmd_valid = 1'b0;
    wr_data = 8'h00;
  end
  // Unused clock bit always sent as zero, data inverted once released
  task wr(input [2:0] c, input [7:0] d);
    begin
      @(posedge clk) #1;
      cmd = c;
      wr_data = (c == 3'h2) ? (d & 8'hDF) : d;
      cmd_valid = 1'b1;
      @(posedge clk) #1;
      cmd_valid = 1'b0;
      wr_data = ~wr_data;
    end
  endtask
  // Read answer taken in its single valid cycle
  task rd(input [2:0] c, output [7:0] d);
    begin
      wr(c, 8'h00);
      d = rd_valid ? rd_data : 8'hXX;
    end
  endtask
endmodule // sys_ctrl_model

/* File: verif/touch_sense_clock_mask_regs_tb.sv */
`timescale 1ns/10ps
// Register, scan and start-up checks against a reference model
module touch_sense_clock_mask_regs_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg core_rst_n = 1'b0;
  reg prim = 1'b0;
  reg sec = 1'b0;
  reg mmode = 1'b0;
  reg roff_wr = 1'b0;
  reg roff_we = 1'b0;
  reg clk_in = 1'b1;
  reg c0;
  reg [7:0] sense = 8'h00;
  reg [7:0] q, a, b, s;
  reg [31:0] lfsr = 32'hC53A;
  wire [2:0] cmd, tune;
  wire [7:0] wr_data, rd_data, sel, rdy;
  wire cmd_valid, rd_valid, roff, clk_out, osc_en, int_p;
  integer mismatches = 0;
  integer check_count = 0;
  integer cycles = 0;
  integer clk_m, mask_m, i, k, n;
  always #25 clk = ~clk;
  sys_ctrl_model ctl (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd(cmd), .cmd_valid(cmd_valid),
    .wr_data(wr_data));
  touch_sense_clock_mask_regs uut (.CORE_CLK(clk), .RST_N(rst_n), .CORE_RST_N(core_rst_n), .CMD(cmd),
    .CMD_VALID(cmd_valid), .WR_DATA(wr_data), .RD_DATA(rd_data), .RD_VALID(rd_valid), .PRIMARY_MODE(prim),
    .SECONDARY_MODE(sec), .MASK_POWER_MODE(mmode), .REGULATOR_OFF_WR(roff_wr), .REGULATOR_OFF_WE(roff_we),
    .REGULATOR_OFF(roff), .CLK_IN(clk_in), .CLK_OUT(clk_out), .SENSE_IN(sense), .SAMPLE_SEL(sel),
    .OSC_ENABLE(osc_en), .OSC_TUNING(tune), .CHANNEL_READY(rdy), .INT_PENDING(int_p));
  function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task conclude;
    begin
      if (mismatches == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task cmp(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Writes update the register model, reads compare with it
  task wrm(input [2:0] c, input [7:0] d);
    begin
      ctl.wr(c, d);
      if (c == 3'h2)
        clk_m = d & 8'hDF;
      if (c == 3'h4)
        mask_m = d;
    end
  endtask
  task chk(input [2:0] c, input [7:0] e);
    begin
      ctl.rd(c, q);
      cmp((c == 3'h3) ? (q & 8'hDF) : q, e);
    end
  endtask
  task do_reset;
    begin
      rst_n = 1'b0;
      core_rst_n = 1'b0;
      clk_m = 12;
      mask_m = 255;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      core_rst_n = 1'b1;
    end
  endtask
  // Next scan slot: gap in k, previous slot in b
  task slot;
    begin
      k = 0;
      @(posedge clk) #1;
      while (sel === 8'h00 && k < 300) begin
        @(posedge clk) #1;
        k = k + 1;
      end
      b = a;
      a = sel;
    end
  endtask
  task edges;
    begin
      n = 0;
      // Let a setting written at the last edge reach the pin first
      @(posedge clk) #1;
      for (k = 0; k < 32; k = k + 1) begin
        c0 = clk_out;
        @(posedge clk) #1;
        n = n + (clk_out !== c0);
      end
    end
  endtask
  task wait_rdy(input [7:0] w);
    begin
      k = 0;
      while ((rdy & w) !== w && k < 3000) begin
        @(posedge clk) #1;
        k = k + 1;
      end
      cmp(rdy & w, w);
    end
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches = mismatches + 1;
      conclude;
    end
  end
  initial begin
    do_reset;
    chk(3'h3, clk_m);
    chk(3'h5, mask_m);
    chk(3'h1, 8'h00);
    cmp(roff, 0);
    // Coarse divider codes set the slot spacing and order
    for (i = 0; i < 4; i = i + 1) begin
      wrm(3'h2, (i << 3) | 4);
      chk(3'h3, clk_m);
      slot;
      slot;
      slot;
      cmp(k, (64 >> (2 * i)) - 1);
      cmp(a, {b[6:0], b[7]});
    end
    // Every tuning code with random clock switches
    for (i = 0; i < 8; i = i + 1) begin
      lfsr = nxt(lfsr);
      wrm(3'h2, (lfsr[7:0] & 8'hD8) | i);
      cmp(tune, i);
      cmp(osc_en, !clk_m[6]);
      chk(3'h3, clk_m);
    end
    wrm(3'h2, 8'h1C);
    edges;
    cmp(n, 0);
    prim = 1'b1;
    edges;
    cmp(n != 0, 1);
    prim = 1'b0;
    wrm(3'h2, 8'h9C);
    edges;
    cmp(n != 0, 1);
    wrm(3'h2, 8'h1C);
    // Low-power mode skips disabled slots, normal mode scans all
    lfsr = nxt(lfsr);
    wrm(3'h4, lfsr[7:0] | 8'h01);
    chk(3'h5, mask_m);
    for (n = 0; n < 2; n = n + 1) begin
      mmode = (n == 0);
      s = 8'h00;
      for (i = 0; i < 20; i = i + 1) begin
        slot;
        if (i > 3)
          s = s | a;
      end
      cmp(s, n ? 8'hFF : mask_m);
    end
    ctl.wr(3'h6, 8'h00);
    chk(3'h5, mask_m);
    // Sensor bits follow enabled channels, reads clear the flag
    wrm(3'h4, 8'h0F);
    wait_rdy(8'h0F);
    lfsr = nxt(lfsr);
    sense = lfsr[7:0] | 8'h01;
    repeat (80) @(posedge clk);
    #1;
    cmp(int_p, 1);
    chk(3'h1, sense & mask_m);
    cmp(int_p, 0);
    chk(3'h0, sense & mask_m);
    wrm(3'h4, 8'hFF);
    repeat (3) @(posedge clk);
    #1;
    cmp(rdy, 8'h0F);
    wait_rdy(8'hFF);
    repeat (80) @(posedge clk);
    #1;
    chk(3'h1, sense);
    // Core reset restarts channels but keeps registers
    core_rst_n = 1'b0;
    @(posedge clk) #1;
    core_rst_n = 1'b1;
    cmp(rdy, 8'h00);
    chk(3'h5, mask_m);
    chk(3'h3, clk_m);
    roff_wr = 1'b1;
    roff_we = 1'b1;
    @(posedge clk) #1;
    roff_we = 1'b0;
    cmp(roff, 1);
    do_reset;
    cmp(roff, 0);
    chk(3'h3, clk_m);
    chk(3'h5, mask_m);
    // Secondary mode scans from the clock input
    sec = 1'b1;
    n = 0;
    for (i = 0; i < 256; i = i + 1) begin
      clk_in = i[1];
      @(posedge clk) #1;
      n = n + (sel != 8'h00);
    end
    cmp(osc_en, 0);
    cmp(n != 0, 1);
    conclude;
  end
endmodule // touch_sense_clock_mask_regs_tb
bind touch_sense_clock_mask_regs touch_sense_clock_mask_regs_checker chk_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .CORE_RST_N(CORE_RST_N), .CMD(CMD), .CMD_VALID(CMD_VALID), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA),
  .RD_VALID(RD_VALID), .SECONDARY_MODE(SECONDARY_MODE), .REGULATOR_OFF_WR(REGULATOR_OFF_WR),
  .REGULATOR_OFF_WE(REGULATOR_OFF_WE), .REGULATOR_OFF(REGULATOR_OFF), .SAMPLE_SEL(SAMPLE_SEL),
  .OSC_ENABLE(OSC_ENABLE), .OSC_TUNING(OSC_TUNING), .CHANNEL_READY(CHANNEL_READY));
